// ===== rcec_keypad.sv
// Pilot keypad and remote mark switch model
`timescale 1ns/10ps
module rcec_keypad (
    input  wire        core_clk,
    output reg  [19:0] key_q,
    output reg         remote_mark_n
);
    // Keys released, remote line inactive high at start
    initial begin
        key_q = 20'h0;
        remote_mark_n = 1'b1;
    end

    // one press; six low cycles so the next press is a new edge
    task press(input int k);
        @(posedge core_clk);
        #1 key_q[k] = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 key_q[k] = 1'b0;
        repeat (6) @(posedge core_clk);
        #2;
    endtask

    // Hold or release a key across other presses
    task set(input int k, input logic lvl);
        @(posedge core_clk);
        #1 key_q[k] = lvl;
    endtask

    task remote_pulse;
        @(posedge core_clk);
        #1 remote_mark_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 remote_mark_n = 1'b1;
        repeat (6) @(posedge core_clk);
        #2;
    endtask
endmodule // rcec_keypad

// ===== rcec_map.vh
// Constants for the reply code entry control block
`ifndef RCEC_MAP_VH
`define RCEC_MAP_VH
`define RCEC_CLK_HZ        25000000
`define RCEC_MARK_SEC      18
`define RCEC_REOPEN_SEC    5
`define RCEC_MARK_CYC      (`RCEC_MARK_SEC * `RCEC_CLK_HZ)
`define RCEC_REOPEN_CYC    (`RCEC_REOPEN_SEC * `RCEC_CLK_HZ)
`define RCEC_PRESET_RST    12'o1200
`define RCEC_CODE_RST      12'o1200
`define RCEC_PAGE_LAST     5'h18
`define RCEC_MODE_OFF      3'h1
`define RCEC_MODE_STANDBY_SETTING     3'h2
`define RCEC_MODE_ON       3'h4
`define RCEC_MODE_ALT      3'h0
`endif

// ===== rcec_sva.sv
// Port-level checks for the reply code entry control block
`timescale 1ns/10ps
`include "rcec_map.vh"
module rcec_sva #(
    parameter MARK_CYC = 50
) (
    input logic        core_clk,
    input logic        sys_rst,
    input logic        key_standby,
    input logic        key_on,
    input logic        page_forward_key,
    input logic        alt_source_fitted,
    input logic [11:0] alt_code_in,
    input logic        powered,
    input logic        reply_enable,
    input logic        alt_in_reply,
    input logic [11:0] reply_alt_code,
    input logic [11:0] active_code,
    input logic        entry_active,
    input logic        spi_enable,
    input logic        config_mode,
    input logic [4:0]  config_page,
    input logic        config_commit,
    input logic        config_discard
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ----------
    // Helper counter
    // ----------
    // Cycles the mark pulse has been up; a repetition cannot count this far
    logic [31:0] mark_run_q;
    always_ff @(posedge core_clk) begin
        mark_run_q <= (sys_rst || !spi_enable) ? 32'h0 : mark_run_q + 32'h1;
    end

    standby_setting_mute_a: assert property (
        $rose(key_standby) && powered |-> ##[5:8] !reply_enable)
        else $error("standby left replies enabled");
    on_noalt_a: assert property (
        $rose(key_on) && powered && !page_forward_key
        |-> ##[5:8] reply_enable && !alt_in_reply)
        else $error("on setting reply flags wrong");
    alt_pass_a: assert property (
        alt_in_reply && $past(alt_in_reply) && $stable(alt_code_in)
        && $past(alt_code_in) == $past(alt_code_in, 2)
        && $past(alt_code_in, 2) == $past(alt_code_in, 3)
        |-> reply_alt_code == alt_code_in)
        else $error("reply altitude differs from source");
    no_src_a: assert property (
        !alt_source_fitted && !$past(alt_source_fitted, 2)
        && !$past(alt_source_fitted, 4) |-> !alt_in_reply)
        else $error("altitude sent without a source");
    mark_len_a: assert property (
        $fell(spi_enable) |-> mark_run_q == MARK_CYC)
        else $error("mark pulse length wrong");
    entry_hold_a: assert property (
        entry_active && $past(entry_active) |-> $stable(active_code))
        else $error("code changed during entry");
    zero_block_a: assert property (
        active_code != 12'h000)
        else $error("reserved code became active");
    cfg_entry_a: assert property (
        $rose(config_mode) |-> page_forward_key)
        else $error("config entered without page key held");
    page_stop_a: assert property (
        config_mode && $past(config_mode) |-> config_page <= `RCEC_PAGE_LAST
        && !($past(config_page) == 5'h0 && config_page == `RCEC_PAGE_LAST))
        else $error("config page out of range or wrapped");
    commit_pulse_a: assert property (
        config_commit |-> config_mode && !config_discard ##1 !config_commit)
        else $error("commit pulse malformed");
endmodule // rcec_sva

// ===== rcec_top.v
// Reply mode, identity code entry and panel control logic
//
// What this block does
// - Standby suppresses every reply
// - Power key from off restores last code
// - On mode replies without altitude
// - Altitude mode sends uncorrected pressure altitude
// - No altitude source: reply without altitude
// - Mark key: pulse and indicator 18 seconds
// - Visual-rules key loads preset code
// - Second visual-rules press restores prior code
// - Octal digit keys start code entry
// - New code active after fourth digit
// - Clear moves cursor back one digit
// - Clear at first digit or cursor aborts
// - Clear within five seconds reopens fourth digit
// - Keys 8 and 9 ignored for codes
// - Code 0000 refused from keypad
// - Config mode only with page-forward at power-up
// - Page-forward advances, timer key backs, no wrap
// - Cursor commits, page-forward discards edits
// - Commits go to nonvolatile store; exit by power
// - Timer key runs timers, clear resets them
// - Flight timer starts when airborne
`timescale 1ns/10ps
`include "rcec_map.vh"

module rcec_top #(
    parameter MARK_CYC   = `RCEC_MARK_CYC,
    parameter REOPEN_CYC = `RCEC_REOPEN_CYC,
    parameter TMR_W      = 32
) (
    input  wire              core_clk,
    input  wire              sys_rst,
    input  wire              key_off,
    input  wire              key_standby,
    input  wire              key_on,
    input  wire              key_alt,
    input  wire              key_mark,
    input  wire              visual_rules_key,
    input  wire              page_forward_key,
    input  wire              timer_key,
    input  wire              cursor_key,
    input  wire              clear_key,
    input  wire [9:0]        digit_key,
    input  wire              remote_mark_n,
    input  wire              airborne,
    input  wire              alt_source_fitted,
    input  wire [11:0]       alt_code_in,
    output reg               powered,
    output reg               reply_enable,
    output reg               alt_in_reply,
    output reg  [11:0]       reply_alt_code,
    output reg  [11:0]       active_code,
    output reg  [11:0]       shown_code,
    output reg  [1:0]        entry_cursor,
    output reg               entry_active,
    output reg               spi_enable,
    output reg               mark_indicator,
    output reg               config_mode,
    output reg  [4:0]        config_page,
    output reg               config_commit,
    output reg               config_discard,
    output reg  [TMR_W-1:0]  count_up_time,
    output reg  [TMR_W-1:0]  count_down_time,
    output reg  [TMR_W-1:0]  flight_time
);

    //------------------------------------------------------------
    // Input capture
    //------------------------------------------------------------
    // Panel keys and discretes arrive from pins; three flops each
    localparam NSYNC = 28;
    wire [NSYNC-1:0] raw_in = {key_off, key_standby, key_on, key_alt,
        key_mark, visual_rules_key, page_forward_key, timer_key,
        cursor_key, clear_key, digit_key, ~remote_mark_n, airborne,
        alt_source_fitted, 5'h00};
    reg  [NSYNC-1:0] s1_q;
    reg  [NSYNC-1:0] s2_q;
    reg  [NSYNC-1:0] s3_q;
    reg  [11:0]      alt1_q;
    reg  [11:0]      alt2_q;
    always @(posedge core_clk) begin
        if (sys_rst) begin
            s1_q   <= {NSYNC{1'b0}};
            s2_q   <= {NSYNC{1'b0}};
            s3_q   <= {NSYNC{1'b0}};
            alt1_q <= 12'h000;
            alt2_q <= 12'h000;
        end else begin
            s1_q   <= raw_in;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            alt1_q <= alt_code_in;
            alt2_q <= alt1_q;
        end
    end

    // Rising edges of the synchronised levels are key presses
    wire [NSYNC-1:0] pr = s2_q & ~s3_q;
    wire p_off  = pr[27];
    wire p_standby_setting = pr[26];
    wire p_on   = pr[25];
    wire p_alt  = pr[24];
    wire p_mark = pr[23] | pr[7];
    wire p_vfr  = pr[22];
    wire p_pgf  = pr[21];
    wire p_tmr  = pr[20];
    wire p_crs  = pr[19];
    wire p_clr  = pr[18];
    wire [9:0] p_dig  = pr[17:8];
    wire pgf_held     = s2_q[21];
    wire is_airborne  = s2_q[6];
    wire alt_fitted   = s2_q[5];

    // Octal value of a digit press; 8 and 9 yield no code digit
    function [3:0] rcec_octal;
        input [9:0] d;
        integer i;
        begin
            rcec_octal = 4'h0;
            for (i = 0; i < 8; i = i + 1)
                if (d[i])
                    rcec_octal = {1'b1, i[2:0]};
        end
    endfunction
    wire [3:0] oct = rcec_octal(p_dig);

    //------------------------------------------------------------
    // Mode selection and code entry
    //------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_ENTRY = 3'b010;
    localparam [2:0] ST_DONE  = 3'b100;
    reg  [2:0]  mode_q;
    reg  [2:0]  st_q;
    reg  [11:0] saved_q;
    reg  [11:0] prevfr_q;
    reg         vfr_on_q;
    reg  [11:0] preset_q;
    reg  [31:0] reopen_q;
    reg  [31:0] mark_q;
    wire        any_pwr = p_standby_setting | p_on | p_alt;
    wire [11:0] cand = {shown_code[11:3], oct[2:0]};

    always @(posedge core_clk) begin
        if (sys_rst) begin
            powered      <= 1'b0;
            mode_q       <= `RCEC_MODE_OFF;
            st_q         <= ST_IDLE;
            active_code  <= `RCEC_CODE_RST;
            shown_code   <= `RCEC_CODE_RST;
            saved_q      <= `RCEC_CODE_RST;
            prevfr_q     <= `RCEC_CODE_RST;
            vfr_on_q     <= 1'b0;
            preset_q     <= `RCEC_PRESET_RST;
            entry_cursor <= 2'h0;
            entry_active <= 1'b0;
            reopen_q     <= 32'h0;
            config_mode  <= 1'b0;
        end else if (p_off) begin
            // Off keeps the last active code for the next power-up
            powered      <= 1'b0;
            mode_q       <= `RCEC_MODE_OFF;
            st_q         <= ST_IDLE;
            entry_active <= 1'b0;
            shown_code   <= active_code;
        end else if (!powered) begin
            if (any_pwr) begin
                powered    <= 1'b1;
                shown_code <= active_code;
                mode_q     <= p_alt ? `RCEC_MODE_ALT :
                              p_on  ? `RCEC_MODE_ON : `RCEC_MODE_STANDBY_SETTING;
                config_mode <= p_on & pgf_held;
            end
        end else begin
            if (p_standby_setting)
                mode_q <= `RCEC_MODE_STANDBY_SETTING;
            else if (p_on)
                mode_q <= `RCEC_MODE_ON;
            else if (p_alt)
                mode_q <= `RCEC_MODE_ALT;
            if (reopen_q != 32'h0)
                reopen_q <= reopen_q - 32'h1;
            case (st_q)
                ST_IDLE, ST_DONE: begin
                    if (!config_mode && oct[3]) begin
                        st_q         <= ST_ENTRY;
                        saved_q      <= active_code;
                        shown_code   <= {oct[2:0], active_code[8:0]};
                        entry_cursor <= 2'h1;
                        entry_active <= 1'b1;
                    end else if (!config_mode && p_clr &&
                                 st_q == ST_DONE && reopen_q != 32'h0) begin
                        st_q         <= ST_ENTRY;
                        entry_cursor <= 2'h3;
                        entry_active <= 1'b1;
                    end else if (!config_mode && p_vfr) begin
                        vfr_on_q <= ~vfr_on_q;
                        if (!vfr_on_q) begin
                            prevfr_q    <= active_code;
                            active_code <= preset_q;
                            shown_code  <= preset_q;
                        end else begin
                            active_code <= prevfr_q;
                            shown_code  <= prevfr_q;
                        end
                    end
                    if (st_q == ST_DONE && reopen_q == 32'h0)
                        st_q <= ST_IDLE;
                end
                ST_ENTRY: begin
                    if (p_crs || (p_clr && entry_cursor == 2'h0)) begin
                        st_q         <= ST_IDLE;
                        entry_active <= 1'b0;
                        shown_code   <= saved_q;
                    end else if (p_clr) begin
                        entry_cursor <= entry_cursor - 2'h1;
                    end else if (oct[3]) begin
                        case (entry_cursor)
                            2'h1: shown_code[8:6] <= oct[2:0];
                            2'h2: shown_code[5:3] <= oct[2:0];
                            2'h3: begin
                                if (cand != 12'h000) begin
                                    active_code  <= cand;
                                    shown_code   <= cand;
                                    st_q         <= ST_DONE;
                                    entry_active <= 1'b0;
                                    vfr_on_q     <= 1'b0;
                                    reopen_q     <= REOPEN_CYC;
                                end
                            end
                            default: shown_code[11:9] <= oct[2:0];
                        endcase
                        if (entry_cursor != 2'h3)
                            entry_cursor <= entry_cursor + 2'h1;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    //------------------------------------------------------------
    // Reply control and position mark
    //------------------------------------------------------------
    // Flags are registered so the reply generator sees clean levels
    always @(posedge core_clk) begin
        if (sys_rst) begin
            reply_enable   <= 1'b0;
            alt_in_reply   <= 1'b0;
            reply_alt_code <= 12'h000;
            mark_q         <= 32'h0;
            spi_enable     <= 1'b0;
            mark_indicator <= 1'b0;
        end else begin
            reply_enable <= powered && mode_q != `RCEC_MODE_STANDBY_SETTING
                            && mode_q != `RCEC_MODE_OFF;
            alt_in_reply <= powered && mode_q == `RCEC_MODE_ALT
                            && alt_fitted;
            reply_alt_code <= alt2_q;
            if (p_mark && powered)
                mark_q <= MARK_CYC;
            else if (mark_q != 32'h0)
                mark_q <= mark_q - 32'h1;
            spi_enable     <= mark_q != 32'h0;
            mark_indicator <= mark_q != 32'h0;
        end
    end

    //------------------------------------------------------------
    // Configuration pages
    //------------------------------------------------------------
    always @(posedge core_clk) begin
        if (sys_rst) begin
            config_page    <= 5'h00;
            config_commit  <= 1'b0;
            config_discard <= 1'b0;
        end else begin
            config_commit  <= 1'b0;
            config_discard <= 1'b0;
            if (config_mode && powered) begin
                if (p_pgf) begin
                    config_discard <= 1'b1;
                    if (config_page != `RCEC_PAGE_LAST)
                        config_page <= config_page + 5'h01;
                end else if (p_tmr && config_page != 5'h00)
                    config_page <= config_page - 5'h01;
                if (p_crs)
                    config_commit <= 1'b1;
            end else
                config_page <= 5'h00;
        end
    end

    //------------------------------------------------------------
    // Timers
    //------------------------------------------------------------
    localparam [24:0] SEC_CYC = `RCEC_CLK_HZ - 1;
    reg  [24:0] sec_q;
    reg         run_q;
    reg         fly_q;
    wire        tick = (sec_q == SEC_CYC);
    always @(posedge core_clk) begin
        if (sys_rst) begin
            sec_q           <= 25'h0;
            run_q           <= 1'b0;
            fly_q           <= 1'b0;
            count_up_time   <= {TMR_W{1'b0}};
            count_down_time <= {TMR_W{1'b0}};
            flight_time     <= {TMR_W{1'b0}};
        end else begin
            sec_q <= tick ? 25'h0 : sec_q + 25'h1;
            if (is_airborne && powered)
                fly_q <= 1'b1;
            if (powered && !config_mode) begin
                if (p_tmr)
                    run_q <= ~run_q;
                if (p_clr && st_q != ST_ENTRY) begin
                    count_up_time   <= {TMR_W{1'b0}};
                    count_down_time <= {TMR_W{1'b0}};
                    flight_time     <= {TMR_W{1'b0}};
                    fly_q           <= 1'b0;
                end else if (tick) begin
                    if (run_q) begin
                        count_up_time <= count_up_time + 1'b1;
                        if (count_down_time != {TMR_W{1'b0}})
                            count_down_time <= count_down_time - 1'b1;
                    end
                    if (run_q | fly_q)
                        flight_time <= flight_time + 1'b1;
                end
            end
        end
    end

endmodule // rcec_top

// ===== tb_reply_code_entry_control.sv
// Self-checking bench for the reply code entry control block
`timescale 1ns/10ps
module tb_reply_code_entry_control;
    localparam MC = 50;
    localparam RC = 60;
    localparam KOFF = 0, KSTBY = 1, KON = 2, KALT = 3, KMARK = 4;
    localparam KVFR = 5, KFWD = 6, KTMR = 7, KCRSR = 8, KCLR = 9, KD = 10;
    logic        core_clk, sys_rst, airborne, alt_source_fitted;
    logic [11:0] alt_code_in;
    wire  [19:0] keys;
    wire         remote_mark_n, powered, reply_enable, alt_in_reply;
    wire         entry_active, spi_enable, mark_indicator, config_mode;
    wire         config_commit, config_discard;
    wire  [11:0] reply_alt_code, active_code, shown_code;
    wire  [1:0]  entry_cursor;
    wire  [4:0]  config_page;
    wire  [31:0] count_up_time, count_down_time, flight_time;
    int          fails, samples_checked, n_commit;

    rcec_top #(.MARK_CYC(MC), .REOPEN_CYC(RC), .TMR_W(32)) u_rcec_top (
        .key_off(keys[0]), .key_standby(keys[1]), .key_on(keys[2]),
        .key_alt(keys[3]), .key_mark(keys[4]), .visual_rules_key(keys[5]),
        .page_forward_key(keys[6]), .timer_key(keys[7]),
        .cursor_key(keys[8]), .clear_key(keys[9]), .digit_key(keys[19:10]),
        .*);
    rcec_keypad u_rcec_keypad (.core_clk(core_clk), .key_q(keys),
        .remote_mark_n(remote_mark_n));

    // 25 MHz clock; commit pulses counted as they pass
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        n_commit += config_commit;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task summarize;
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task p(input int k);
        u_rcec_keypad.press(k);
    endtask
    // Codes are given as octal digits packed three bits each
    task enter(input logic [11:0] c);
        for (int i = 3; i >= 0; i--) p(KD + c[3*i +: 3]);
    endtask

    // ----------
    // Scenarios
    // ----------
    task t_power;
        p(KMARK);
        chk({powered, spi_enable}, 2'h0);
        p(KON);
        chk({powered, config_mode}, 2'h2);
        chk(active_code, 12'h280);
        chk(shown_code, 12'h280);
    endtask
    // Altitude source value stays put so the reply copy is comparable
    task t_modes;
        alt_source_fitted = 1'b1;
        p(KSTBY);
        chk(reply_enable, 1'b0);
        p(KON);
        chk({reply_enable, alt_in_reply}, 2'h2);
        p(KALT);
        chk({reply_enable, alt_in_reply, reply_alt_code}, 14'h3A5C);
        alt_source_fitted = 1'b0;
        repeat (6) @(posedge core_clk);
        #2;
        chk({reply_enable, alt_in_reply}, 2'h2);
    endtask
    task t_entry;
        p(KD + 1);
        chk({entry_active, entry_cursor}, 3'h5);
        p(KD + 8);
        chk(entry_cursor, 2'h1);
        p(KD + 2);
        p(KD + 3);
        chk(active_code, 12'h280);
        p(KD + 4);
        chk({entry_active, active_code}, 13'h029C);
        enter(12'h000);
        chk({entry_active, entry_cursor, active_code}, 15'h729C);
        p(KCRSR);
        chk({entry_active, active_code}, 13'h029C);
    endtask
    task t_clear;
        p(KD + 5);
        p(KD + 6);
        p(KCLR);
        chk(entry_cursor, 2'h1);
        p(KCLR);
        chk({entry_active, entry_cursor}, 3'h4);
        p(KCLR);
        chk({entry_active, active_code}, 13'h029C);
        enter(12'h977);
        p(KCLR);
        chk({entry_active, entry_cursor}, 3'h7);
        p(KD + 1);
        chk(active_code, 12'h971);
        repeat (RC + 20) @(posedge core_clk);
        p(KCLR);
        chk(entry_active, 1'b0);
    endtask
    // Lower bound here; the exact length is left to the checker
    task t_mark(input logic remote);
        int n;
        if (remote) u_rcec_keypad.remote_pulse;
        else p(KMARK);
        chk({spi_enable, mark_indicator}, 2'h3);
        repeat (MC - 15) @(posedge core_clk);
        #2;
        chk(spi_enable, 1'b1);
        n = 0;
        while (spi_enable !== 1'b0) begin
            if (n++ > 30) begin
                fails++;
                summarize;
            end
            @(posedge core_clk);
            #2;
        end
        repeat (3) @(posedge core_clk);
        #2;
        chk({spi_enable, mark_indicator}, 2'h0);
    endtask
    task t_visual;
        p(KVFR);
        chk(active_code, 12'h280);
        p(KVFR);
        chk(active_code, 12'h971);
    endtask
    task t_config;
        p(KOFF);
        u_rcec_keypad.set(KFWD, 1'b1);
        p(KON);
        u_rcec_keypad.set(KFWD, 1'b0);
        chk({powered, config_mode, config_page}, 7'h60);
        p(KFWD);
        chk(config_page, 5'h01);
        p(KTMR);
        chk(config_page, 5'h00);
        p(KTMR);
        chk(config_page, 5'h00);
        n_commit = 0;
        p(KCRSR);
        chk(n_commit, 1);
        p(KOFF);
        p(KON);
        chk({powered, config_mode}, 2'h2);
    endtask
    // Timers tick in seconds, too slow to see run; only the reset shows
    task t_timers;
        airborne = 1'b1;
        p(KTMR);
        p(KCLR);
        chk(count_up_time, 32'h0);
        chk(count_down_time, 32'h0);
        chk(flight_time, 32'h0);
    endtask

    initial begin
        sys_rst = 1'b1;
        airborne = 1'b0;
        alt_source_fitted = 1'b0;
        alt_code_in = 12'hA5C;
        fails = 0;
        samples_checked = 0;
        n_commit = 0;
        repeat (3) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        t_power;
        t_modes;
        t_entry;
        t_clear;
        t_mark(1'b0);
        t_mark(1'b1);
        t_visual;
        t_config;
        t_timers;
        summarize;
    end
endmodule // tb_reply_code_entry_control

bind rcec_top rcec_sva #(.MARK_CYC(MARK_CYC)) u_rcec_sva (.*);
